// ### hdl/cgc_charger_ctrl.v
// Purpose: enable sequencing, soft-start and gate drive of a buck charger
// Assumes: comparator results arrive asynchronously; srst is the supply lockout
// Notes: analog loops are outside; duty_req is the digitised pwm request
`timescale 1ns/1ps
`include "cgc_regs.vh"

// Summary of operation
// - supply below lockout holds bias, charge path and both drives off
// - supply good, adapter sense low: partial bias, input current monitor grounded
// - adapter sense above low threshold: all bias and monitor enabled
// - adapter above valid threshold: release adapter good, attempt to charge
// - charge only when disable low, all supplies, adapter and delay good
// - any fault or disable stops an ongoing charge, except loss of reference good or gate regulator good
// - thermal shutdown flag comes in with comparator hysteresis
// - each enable ramps target from zero in 8 equal steps
// - each soft-start step holds about 1.7 ms
// - fixed 300 kHz switching period from the clock
// - duty request spans zero to a full period
// - full period request still reaches near full duty with bootstrap kept
// - bootstrap low at a period end forces a low-side refresh pulse; 3 such periods in a row raise the refresh event
// - non-synchronous below sync threshold, synchronous otherwise
// - synchronous: low side on when high off, 30 ns dead time rounded up to one 100 ns clock
// - non-synchronous: 80 ns low-side pulse rounded up to one 100 ns clock after dead time, then off
// - bootstrap low: only the refresh pulse, high side held off
module cgc_charger_ctrl #(
  parameter DETECT_CYC = `CGC_DETECT_CYC,
  parameter STEP_CYC = `CGC_STEP_CYC,
  parameter DUTY_W = 6
)
(
  input wire ref_clk,
  input wire srst,
  input wire supply_ok_async,
  input wire adapter_sense_low_async,
  input wire adapter_sense_valid_async,
  input wire adapter_above_supply_async,
  input wire adapter_ovp_async,
  input wire adapter_ocp_async,
  input wire thermal_hot_async,
  input wire reference_good_async,
  input wire gate_regulator_good_async,
  input wire charge_disable_pin_async,
  input wire current_below_sync_async,
  input wire boot_low_async,
  input wire [DUTY_W-1:0] duty_req,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  output reg partial_bias_en,
  output reg full_bias_en,
  output reg input_current_monitor_en,
  output reg adapter_good_flag_out,
  output reg adapter_good_flag_oe,
  output reg charge_en,
  output reg thermal_shutdown,
  output reg [3:0] ss_step,
  output reg high_side_drive,
  output reg low_side_drive,
  output reg sync_mode,
  output reg irq
);

  localparam NIN = 12;
  localparam PER = `CGC_PERIOD_CYC;
  localparam DEAD = `CGC_DEAD_CYC;
  localparam REFR = `CGC_REFRESH_CYC;
  localparam S_HIGH = 2'd0;
  localparam S_DEAD = 2'd1;
  localparam S_LOW = 2'd2;
  localparam S_IDLE = 2'd3;

  wire [NIN-1:0] raw_in;
  reg [NIN-1:0] sy1;
  reg [NIN-1:0] sy2;
  reg [NIN-1:0] sy3;
  reg [NIN-1:0] qin;
  assign raw_in = {boot_low_async, current_below_sync_async, charge_disable_pin_async,
    gate_regulator_good_async, reference_good_async, thermal_hot_async, adapter_ocp_async,
    adapter_ovp_async, adapter_above_supply_async, adapter_sense_valid_async,
    adapter_sense_low_async, supply_ok_async};

  // three stage sync; a change counts when stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi = gi + 1)
    begin : g_sync
      always @(posedge ref_clk)
      begin
        if (srst)
        begin
          sy1[gi] <= 1'b0;
          sy2[gi] <= 1'b0;
          sy3[gi] <= 1'b0;
          qin[gi] <= 1'b0;
        end
        else
        begin
          sy1[gi] <= raw_in[gi];
          sy2[gi] <= sy1[gi];
          sy3[gi] <= sy2[gi];
          if (sy2[gi] == sy3[gi])
            qin[gi] <= sy3[gi];
        end
      end
    end
  endgenerate

  wire supply_ok = qin[0];
  wire ad_low = qin[1];
  wire ad_valid = qin[2];
  wire ad_above = qin[3];
  wire ad_ovp = qin[4];
  wire ad_ocp = qin[5];
  wire hot = qin[6];
  wire ref_good = qin[7];
  wire reg_good = qin[8];
  wire dis_pin = qin[9];
  wire below_sync = qin[10];
  wire boot_low = qin[11];

  reg [31:0] ctrl;
  reg [31:0] irq_mask;
  reg [4:0] irq_stat;
  reg [31:0] det_cnt;
  reg det_done;
  reg [31:0] step_cnt;
  reg [1:0] gstate;
  reg [7:0] pcnt;
  reg [7:0] scnt;
  reg [1:0] boot_periods;
  reg refresh_pend;
  reg refresh_now;
  reg adapter_q;
  reg therm_q;

  wire sw_disable = ctrl[0];
  wire ok_to_start = !dis_pin && !sw_disable && supply_ok && ad_valid && ad_above && !ad_ovp &&
    det_done && ref_good && reg_good && !thermal_shutdown;
  wire stop_now = dis_pin || sw_disable || !supply_ok || !ad_valid || !ad_above || ad_ovp ||
    ad_ocp || thermal_shutdown;
  wire period_end = (pcnt == PER - 1);
  // a standing stop condition (overcurrent) must not let charge toggle back on
  wire ev_on = ok_to_start && !stop_now && !charge_en;
  wire ev_off = charge_en && stop_now;

  // bias, adapter good and thermal flag
  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      partial_bias_en <= 1'b0;
      full_bias_en <= 1'b0;
      input_current_monitor_en <= 1'b0;
      adapter_good_flag_out <= 1'b0;
      adapter_good_flag_oe <= 1'b0;
      thermal_shutdown <= 1'b0;
    end
    else
    begin
      partial_bias_en <= supply_ok;
      full_bias_en <= supply_ok && ad_low;
      input_current_monitor_en <= supply_ok && ad_low;
      adapter_good_flag_out <= 1'b0;
      // released when adapter valid so the pull-up shows good, pulled low otherwise
      adapter_good_flag_oe <= !(supply_ok && ad_valid);
      // comparator carries the 155/135 hysteresis
      thermal_shutdown <= hot;
    end
  end

  // post-detect delay
  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      det_cnt <= 32'h0000_0000;
      det_done <= 1'b0;
    end
    else if (!(supply_ok && ad_valid))
    begin
      det_cnt <= 32'h0000_0000;
      det_done <= 1'b0;
    end
    else if (det_cnt >= DETECT_CYC - 1)
      det_done <= 1'b1;
    else
      det_cnt <= det_cnt + 32'h0000_0001;
  end

  // charge enable and soft-start
  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      charge_en <= 1'b0;
      ss_step <= 4'h0;
      step_cnt <= 32'h0000_0000;
    end
    else if (ev_off || !charge_en)
    begin
      charge_en <= ev_on;
      ss_step <= 4'h0;
      step_cnt <= 32'h0000_0000;
    end
    else if (ss_step != `CGC_SS_STEPS)
    begin
      if (step_cnt >= STEP_CYC - 1)
      begin
        step_cnt <= 32'h0000_0000;
        ss_step <= ss_step + 4'h1;
      end
      else
        step_cnt <= step_cnt + 32'h0000_0001;
    end
  end

  // switching period and bootstrap watch
  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      pcnt <= 8'h00;
      boot_periods <= 2'd0;
      refresh_pend <= 1'b0;
      refresh_now <= 1'b0;
      sync_mode <= 1'b0;
    end
    else
    begin
      pcnt <= period_end ? 8'h00 : pcnt + 8'h01;
      if (period_end)
      begin
        sync_mode <= !below_sync;
        refresh_now <= refresh_pend || boot_low;
        refresh_pend <= 1'b0;
        if (!boot_low)
          boot_periods <= 2'd0;
        else if (boot_periods == `CGC_BOOT_LOW_PERIODS - 1)
        begin
          boot_periods <= 2'd0;
          refresh_pend <= 1'b1;
        end
        else
          boot_periods <= boot_periods + 2'd1;
      end
    end
  end

  // gate drive sequence
  wire [7:0] on_cyc = (duty_req >= PER) ? 8'd255 : {{(8-DUTY_W){1'b0}}, duty_req};
  wire full_req = (on_cyc == 8'd255);
  always @(posedge ref_clk)
  begin
    if (srst || !charge_en)
    begin
      gstate <= S_IDLE;
      high_side_drive <= 1'b0;
      low_side_drive <= 1'b0;
      scnt <= 8'h00;
    end
    else
    begin
      scnt <= scnt + 8'h01;
      case (gstate)
        S_HIGH:
        begin
          if ((!full_req && pcnt >= on_cyc) || (period_end && refresh_now))
          begin
            high_side_drive <= 1'b0;
            gstate <= S_DEAD;
            scnt <= 8'h00;
          end
        end
        S_DEAD:
        begin
          if (scnt >= DEAD - 1)
          begin
            if (high_side_drive == 1'b0 && low_side_drive == 1'b0 && gstate == S_DEAD)
              low_side_drive <= 1'b1;
            gstate <= S_LOW;
            scnt <= 8'h00;
          end
        end
        S_LOW:
        begin
          if ((!sync_mode || refresh_now) && scnt >= REFR - 1)
            low_side_drive <= 1'b0;
          if (period_end)
          begin
            low_side_drive <= 1'b0;
            gstate <= S_IDLE;
            scnt <= 8'h00;
          end
        end
        S_IDLE:
        begin
          if (scnt >= DEAD - 1 && pcnt == 8'h00)
          begin
            if (refresh_now)
            begin
              gstate <= S_DEAD;
              scnt <= 8'h00;
            end
            else if (on_cyc != 8'h00)
            begin
              high_side_drive <= 1'b1;
              gstate <= S_HIGH;
            end
          end
        end
        default: gstate <= S_IDLE;
      endcase
    end
  end

  // registers, events and interrupt
  wire rd_stat = avs_read && !avs_waitrequest && avs_address == `CGC_OFF_IRQ_STAT;
  wire [4:0] ev = {refresh_pend && period_end, thermal_shutdown != therm_q,
    ad_valid != adapter_q, ev_off, ev_on};
  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      ctrl <= `CGC_CTRL_RESET;
      irq_mask <= `CGC_MASK_RESET;
      irq_stat <= 5'h00;
      avs_readdata <= 32'h0000_0000;
      avs_waitrequest <= 1'b1;
      adapter_q <= 1'b0;
      therm_q <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      adapter_q <= ad_valid;
      therm_q <= thermal_shutdown;
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
      irq_stat <= (rd_stat ? 5'h00 : irq_stat) | ev;
      irq <= |(irq_stat & irq_mask[4:0]);
      if (avs_write && !avs_waitrequest)
      begin
        if (avs_address == `CGC_OFF_CTRL)
          ctrl <= {31'h0000_0000, avs_writedata[0]};
        if (avs_address == `CGC_OFF_IRQ_MASK)
          irq_mask <= {27'h000_0000, avs_writedata[4:0]};
      end
      if (avs_read && avs_waitrequest)
      begin
        case (avs_address)
          `CGC_OFF_CTRL: avs_readdata <= ctrl;
          `CGC_OFF_STATUS: avs_readdata <= {20'h0_0000, ss_step, sync_mode, thermal_shutdown,
            det_done, charge_en, ad_valid, full_bias_en, partial_bias_en, supply_ok};
          `CGC_OFF_IRQ_STAT: avs_readdata <= {27'h000_0000, irq_stat};
          `CGC_OFF_IRQ_MASK: avs_readdata <= irq_mask;
          default: avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule // cgc_charger_ctrl

// ### hdl/cgc_regs.vh
// Purpose: constants for the charger enable and gate control block
// Assumes: 10 MHz ref_clk, Avalon-MM byte addressing of 32-bit registers
// Notes: offsets are byte addresses
`ifndef CGC_REGS_VH
`define CGC_REGS_VH
`define CGC_CLK_HZ 10000000
`define CGC_DETECT_MS 1200
`define CGC_DETECT_CYC ((`CGC_CLK_HZ / 1000) * `CGC_DETECT_MS)
`define CGC_STEP_US 1700
`define CGC_STEP_CYC ((`CGC_CLK_HZ / 1000000) * `CGC_STEP_US)
`define CGC_SS_STEPS 8
`define CGC_SW_KHZ 300
`define CGC_PERIOD_CYC (`CGC_CLK_HZ / (`CGC_SW_KHZ * 1000))
`define CGC_DEAD_NS 30
`define CGC_DEAD_CYC ((`CGC_DEAD_NS * 10 + 999) / 1000)
`define CGC_REFRESH_NS 80
`define CGC_REFRESH_CYC (((`CGC_REFRESH_NS * 10) / 1000) < 1 ? 1 : ((`CGC_REFRESH_NS * 10) / 1000))
`define CGC_BOOT_LOW_PERIODS 3
`define CGC_OFF_CTRL 4'h0
`define CGC_OFF_STATUS 4'h4
`define CGC_OFF_IRQ_STAT 4'h8
`define CGC_OFF_IRQ_MASK 4'hc
`define CGC_CTRL_RESET 32'h0000_0000
`define CGC_MASK_RESET 32'h0000_0000
`define CGC_IRQ_CHG_ON 0
`define CGC_IRQ_CHG_OFF 1
`define CGC_IRQ_ADAPTER 2
`define CGC_IRQ_THERMAL 3
`define CGC_IRQ_REFRESH 4
`endif

// ### sim/cgc_charger_chk_assertions.sv
// Purpose: port assertions for cgc_charger_ctrl
// Assumes: comparator levels settle within 4 clocks
// Notes: bound below the module
`timescale 1ns/1ps
module cgc_charger_chk #(
  parameter STEP_CYC = 20
)
(
  input wire ref_clk,
  input wire srst,
  input wire supply_ok_async,
  input wire boot_low_async,
  input wire avs_read,
  input wire avs_write,
  input wire avs_waitrequest,
  input wire partial_bias_en,
  input wire full_bias_en,
  input wire input_current_monitor_en,
  input wire adapter_good_flag_oe,
  input wire charge_en,
  input wire thermal_shutdown,
  input wire [3:0] ss_step,
  input wire high_side_drive,
  input wire low_side_drive,
  input wire sync_mode
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  int lo_cnt = 0;
  int bt_cnt = 0;
  int hi_gap = 0;
  int hold = 0;
  int ls_gap = 0;
  always @(posedge ref_clk)
  begin
    lo_cnt <= supply_ok_async ? 0 : lo_cnt + 1;
    bt_cnt <= (boot_low_async && charge_en) ? bt_cnt + 1 : 0;
    hi_gap <= srst ? 100 : ($rose(high_side_drive) ? 1 : hi_gap + 1);
    hold <= $changed(ss_step) ? 1 : hold + 1;
    ls_gap <= low_side_drive ? 0 : ls_gap + 1;
  end
  a_no_shoot_thru: assert property (!(high_side_drive && low_side_drive))
    else $error("both switches on");
  a_lockout_off: assert property (lo_cnt > 5 |->
    !(partial_bias_en || full_bias_en || charge_en || high_side_drive || low_side_drive))
    else $error("active during lockout");
  a_monitor_bias: assert property (input_current_monitor_en == full_bias_en)
    else $error("monitor and full bias differ");
  a_charge_gates: assert property (charge_en |-> !adapter_good_flag_oe && !$past(thermal_shutdown) && full_bias_en)
    else $error("charge without conditions");
  a_ss_idle: assert property (!charge_en ##1 !charge_en |-> ss_step == 4'h0)
    else $error("soft-start not at zero");
  a_ss_steps: assert property ($changed(ss_step) |-> ss_step <= 4'h8 &&
    (ss_step == $past(ss_step) + 4'h1 || ss_step == 4'h0))
    else $error("soft-start step jump");
  a_ss_hold: assert property ($changed(ss_step) && ss_step > 4'h1 |-> hold inside {[STEP_CYC-1:STEP_CYC+1]})
    else $error("soft-start step length");
  a_sw_period: assert property ($rose(high_side_drive) |-> hi_gap >= 33)
    else $error("switching period short");
  a_dead_time: assert property ($fell(high_side_drive) |-> !low_side_drive)
    else $error("no dead time");
  a_dcm_pulse: assert property (!sync_mode && !$past(sync_mode) && $rose(low_side_drive) |=> !low_side_drive)
    else $error("low pulse too long");
  a_boot_refresh: assert property (bt_cnt > 200 |-> !high_side_drive && ls_gap < 40)
    else $error("bootstrap refresh missing");
  a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  c_charge_on: cover property ($rose(charge_en));
  c_ramp_done: cover property (ss_step == 4'h8);
  c_dcm: cover property (!sync_mode && $rose(low_side_drive));
endmodule // cgc_charger_chk

bind cgc_charger_ctrl cgc_charger_chk #(.STEP_CYC(STEP_CYC)) i_cgc_charger_chk (.ref_clk, .srst,
  .supply_ok_async, .boot_low_async, .avs_read, .avs_write, .avs_waitrequest, .partial_bias_en,
  .full_bias_en, .input_current_monitor_en, .adapter_good_flag_oe, .charge_en, .thermal_shutdown,
  .ss_step, .high_side_drive, .low_side_drive, .sync_mode);

// ### sim/cgc_switch_model.sv
// Purpose: bootstrap capacitor of the external switch pair
// Assumes: charge leaks away unless the low side pulls the node down
// Notes: hold_low forces a flat bootstrap
`timescale 1ns/1ps
module cgc_switch_model #(
  parameter LEAK = 2000
)
(
  input wire ref_clk,
  input wire low_side_drive,
  input wire hold_low,
  output reg boot_low = 1'b0
);
  int drain = 0;
  always @(posedge ref_clk)
  begin
    drain = low_side_drive ? 0 : drain + 1;
    boot_low <= hold_low || drain > LEAK;
  end
endmodule // cgc_switch_model

// ### sim/test_charger_enable_and_gate_control.sv
// Purpose: self-checking bench for cgc_charger_ctrl
// Assumes: shortened detect and step counts
// Notes: cond = supply,low,valid,above,ovp,ocp,hot,refg,regg,disable
`timescale 1ns/1ps
module test_charger_enable_and_gate_control;
  localparam int DET = 50;
  localparam int STP = 20;
  localparam logic [9:0] GOOD = 10'h3c6;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic [9:0] cond = 10'h000;
  logic below = 1'b0;
  logic hold_low = 1'b0;
  logic [5:0] duty = 6'h00;
  logic [3:0] adr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0000_0000;
  logic [31:0] q;
  logic [31:0] seed = 32'h0000_52ad;
  wire [31:0] rdata;
  wire [3:0] ss;
  wire busy, pb, fb, mon, ag, ag_oe, chg, hot, hs, ls, sm, irq, boot;
  int err_count = 0;
  int n_compared = 0;
  int hi, lo;
  int kill[7] = '{0, 3, 4, 5, 6, 7, 9};

  always #50 ref_clk = ~ref_clk;

  cgc_charger_ctrl #(.DETECT_CYC(DET), .STEP_CYC(STP)) i_cgc_charger_ctrl (.ref_clk(ref_clk), .srst(srst),
    .supply_ok_async(cond[9]), .adapter_sense_low_async(cond[8]), .adapter_sense_valid_async(cond[7]),
    .adapter_above_supply_async(cond[6]), .adapter_ovp_async(cond[5]), .adapter_ocp_async(cond[4]),
    .thermal_hot_async(cond[3]), .reference_good_async(cond[2]), .gate_regulator_good_async(cond[1]),
    .charge_disable_pin_async(cond[0]), .current_below_sync_async(below), .boot_low_async(boot),
    .duty_req(duty), .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
    .avs_readdata(rdata), .avs_waitrequest(busy), .partial_bias_en(pb), .full_bias_en(fb),
    .input_current_monitor_en(mon), .adapter_good_flag_out(ag), .adapter_good_flag_oe(ag_oe),
    .charge_en(chg), .thermal_shutdown(hot), .ss_step(ss), .high_side_drive(hs), .low_side_drive(ls),
    .sync_mode(sm), .irq(irq));
  cgc_switch_model i_cgc_switch_model (.ref_clk(ref_clk), .low_side_drive(ls), .hold_low(hold_low), .boot_low(boot));

  function logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // charging allowed only with every enable condition met
  function logic exp_ok(input logic [9:0] c);
    return c === GOOD;
  endfunction

  task chk(input logic [31:0] got, input logic [31:0] exp);
  begin
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  end
  endtask

  task wt(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
  begin
    n = 0;
    adr <= a;
    wr <= w;
    rd <= !w;
    wd <= d;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (busy !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    chk(n, 2);
    @(posedge ref_clk);
  end
  endtask

  task win(input int n);
  begin
    hi = 0;
    lo = 0;
    repeat (n)
    begin
      @(posedge ref_clk);
      hi += hs;
      lo += ls;
    end
  end
  endtask

  task print_verdict;
  begin
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  end
  endtask

  initial
  begin
    wt(6);
    srst <= 1'b0;
    wt(1);
    bus(0, 4'h0, 0);
    chk(q, 32'h0000_0000);
    bus(0, 4'hc, 0);
    chk(q, 32'h0000_0000);
    bus(1, 4'h0, 1);
    bus(0, 4'h0, 0);
    chk(q, 32'h0000_0001);
    bus(1, 4'h0, 0);
    bus(1, 4'h2, 32'hffff_ffff);
    bus(0, 4'h2, 0);
    chk(q, 32'h0000_0000);
    $display("registers done");
    cond <= 10'h200;
    wt(10);
    chk({pb, fb, mon}, 3'b100);
    cond <= 10'h300;
    wt(10);
    chk({fb, mon}, 2'b11);
    chk(ag_oe, 1);
    cond <= GOOD;
    wt(10);
    chk(ag_oe, 0);
    chk(ag, 0);
    wt(10);
    chk(chg, 0);
    wt(DET);
    chk(chg, exp_ok(cond));
    wt(9 * STP);
    chk(ss, 8);
    bus(0, 4'h4, 0);
    chk(q[11:8], 8);
    $display("bring-up done");
    bus(1, 4'hc, 2);
    bus(0, 4'h8, 0);
    for (int k = 0; k < 7; k++)
    begin
      cond <= GOOD ^ (10'h001 << kill[k]);
      wt(10);
      chk(chg, exp_ok(cond));
      chk(hot, cond[3]);
      chk(irq, 1);
      bus(0, 4'h8, 0);
      chk(q[1], 1);
      wt(3);
      chk(irq, 0);
      cond <= GOOD;
      if (kill[k] == 7)
      begin
        wt(DET / 2);
        chk(chg, 0);
      end
      wt(DET + 20);
      chk(chg, 1);
    end
    bus(1, 4'hc, 0);
    cond <= GOOD ^ 10'h001;
    wt(10);
    chk(irq, 0);
    cond <= GOOD;
    wt(DET + 20);
    $display("faults done");
    repeat (4)
    begin
      seed = nx(seed);
      duty <= 6'(seed % 30 + 1);
      below <= seed[7];
      wt(80);
      win(33);
      chk(hi, duty);
      chk(sm, !below);
      if (below)
        chk(lo, 1);
    end
    duty <= 6'h00;
    wt(40);
    win(66);
    chk(hi, 0);
    duty <= 6'h3f;
    wt(40);
    win(330);
    chk(hi, 330);
    chk(lo, 0);
    hold_low <= 1'b1;
    wt(220);
    win(99);
    chk({hi[7:0], lo[7:0]}, 16'h0003);
    hold_low <= 1'b0;
    wt(80);
    win(99);
    chk({hi[7:0], lo[7:0]}, 16'h6300);
    $display("gate done");
    print_verdict;
  end

  initial
  begin
    #2_000_000;
    err_count++;
    print_verdict;
  end
endmodule // test_charger_enable_and_gate_control
